// ---- design/ads_pkg.sv ----
// Constants and types for the antenna driver signal select block.
// Assumes the control words arrive as plain register ports.
package ads_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PMOS_W = 6;  // PMOS conductance code width
    localparam int NMOS_W = 4;  // One NMOS field width
    localparam int REG_W  = 8;  // Control register width

    // ------------------------------------------------------------
    // Transmit control register fields
    // ------------------------------------------------------------
    localparam int CTL_OUT1_EN   = 0;
    localparam int CTL_OUT2_EN   = 1;
    localparam int CTL_FORCE_ASK = 2;
    localparam int CTL_OUT2_CW   = 3;
    localparam int CTL_INV1_OFF  = 4;
    localparam int CTL_INV2_OFF  = 5;
    localparam int CTL_INV1_ON   = 6;
    localparam int CTL_INV2_ON   = 7;

    // ------------------------------------------------------------
    // Other register fields
    // ------------------------------------------------------------
    localparam int NMOS_CW_LSB   = 4;  // Continuous-wave NMOS field
    localparam int NMOS_MOD_LSB  = 0;  // Modulation NMOS field
    localparam int TXS_MOUT_LSB  = 0;  // Modem output source, 4 bits
    localparam int TXS_DRV_LSB   = 4;  // Driver source, 2 bits
    localparam int RXS_SRC_LSB   = 6;  // Receive source, 2 bits
    localparam int TXM_INVMOD    = 3;  // Invert envelope
    localparam int TXM_SPEED_LSB = 4;  // Rate code, 3 bits
    localparam int TXM_FRAME     = 7;  // Framing enable
    localparam int SPEED_W       = 3;

    // ------------------------------------------------------------
    // Carrier timing
    // ------------------------------------------------------------
    localparam int XTAL_KHZ    = 27120;
    localparam int CARRIER_DIV = 2;
    localparam int CARRIER_KHZ = XTAL_KHZ / CARRIER_DIV;

    // ------------------------------------------------------------
    // Modem output source codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] MOUT_LOW  = 4'h0;
    localparam logic [3:0] MOUT_HIGH = 4'h1;
    localparam logic [3:0] MOUT_ENV  = 4'h2;
    localparam logic [3:0] MOUT_ENC  = 4'h4;
    localparam logic [3:0] MOUT_RX   = 4'h6;
    localparam logic       OUT_RST   = 1'h0;

    typedef enum logic [1:0] {
        ADS_DRV_OFF  = 2'h0,
        ADS_DRV_INT  = 2'h1,
        ADS_DRV_PIN  = 2'h2,
        ADS_DRV_HIGH = 2'h3
    } ads_drv_src_t;

    typedef enum logic [1:0] {
        ADS_RX_LOW = 2'h0,
        ADS_RX_PIN = 2'h1,
        ADS_RX_INT = 2'h2,
        ADS_RX_ALT = 2'h3
    } ads_rx_src_t;

endpackage

// ---- design/ads_sig_if.sv ----
// Carrier and drive envelope passed among the block's modules.
// Assumes all parties run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface ads_sig_if;
    logic carrier;       // Present carrier phase
    logic carrier_next;  // Phase in the coming cycle
    logic drive_env;     // Envelope chosen for the drivers

    modport div (output carrier, output carrier_next);
    modport sw  (output drive_env);
    modport top (input carrier, input carrier_next, input drive_env);
endinterface
`default_nettype wire

// ---- design/ads_carrier_div.sv ----
// Carrier divider: halves the crystal clock into the carrier.
// Assumes clock is the crystal oscillator clock.
`timescale 1ns/10ps
`default_nettype none
module ads_carrier_div
    import ads_pkg::*;
(
    input  wire logic clock,
    input  wire logic nrst,
    ads_sig_if.div    sig
);

    logic carrier_reg;
    logic carrier_next;

    // ------------------------------------------------------------
    // Divide by two
    // ------------------------------------------------------------
    // Toggle every rising edge; next phase is published so outputs line up
    always_comb begin
        carrier_next = ~carrier_reg;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            carrier_reg <= OUT_RST;
        end else begin
            carrier_reg <= carrier_next;
        end
    end

    assign sig.carrier      = carrier_reg;
    assign sig.carrier_next = carrier_next;

    a_carrier_period: assert property (@(posedge clock) disable iff (!nrst)
        carrier_reg |=> !carrier_reg ##1 carrier_reg)
        else $error("Carrier period is not two clocks");

endmodule
`default_nettype wire

// ---- design/ads_data_switch.sv ----
// Serial data switch between digital coder and analog front end.
// Assumes modem_input_pin is asynchronous; other inputs share clock.
`timescale 1ns/10ps
`default_nettype none
module ads_data_switch
    import ads_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [3:0]  mout_sel,
    input  wire logic [1:0]  drv_sel,
    input  wire logic [1:0]  rx_sel,
    input  wire logic        tx_envelope,
    input  wire logic        tx_encoded,
    input  wire logic        analog_rx_data,
    input  wire logic        modem_input_pin,
    output logic             modem_output_pin,
    output logic             rx_serial_data,
    ads_sig_if.sw            sig
);

    logic pin_s1_reg, pin_s2_reg;
    logic pin_s1_next, pin_s2_next;
    logic mout_reg, mout_next;
    logic rx_reg, rx_next;

    // ------------------------------------------------------------
    // Routing
    // ------------------------------------------------------------
    // Pin input is synchronised before any route may see it
    always_comb begin
        pin_s1_next = modem_input_pin;
        pin_s2_next = pin_s1_reg;
        case (mout_sel)
            MOUT_HIGH: mout_next = 1'b1;
            MOUT_ENV:  mout_next = tx_envelope;
            MOUT_ENC:  mout_next = tx_encoded;
            MOUT_RX:   mout_next = analog_rx_data;
            default:   mout_next = 1'b0;
        endcase
        case (ads_rx_src_t'(rx_sel))
            ADS_RX_PIN: rx_next = pin_s2_reg;
            ADS_RX_INT: rx_next = analog_rx_data;
            ADS_RX_ALT: rx_next = analog_rx_data;
            default:    rx_next = 1'b0;
        endcase
        case (ads_drv_src_t'(drv_sel))
            ADS_DRV_INT:  sig.drive_env = tx_envelope;
            ADS_DRV_PIN:  sig.drive_env = pin_s2_reg;
            ADS_DRV_HIGH: sig.drive_env = 1'b1;
            default:      sig.drive_env = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_s1_reg <= OUT_RST;
            pin_s2_reg <= OUT_RST;
            mout_reg   <= OUT_RST;
            rx_reg     <= OUT_RST;
        end else begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
            mout_reg   <= mout_next;
            rx_reg     <= rx_next;
        end
    end

    assign modem_output_pin = mout_reg;
    assign rx_serial_data   = rx_reg;

    a_mout_high: assert property (@(posedge clock) disable iff (!nrst)
        mout_sel == MOUT_HIGH |=> modem_output_pin)
        else $error("Modem output not high when selected");
    a_rx_internal: assert property (@(posedge clock) disable iff (!nrst)
        rx_sel == 2'h2 |=> rx_serial_data == $past(analog_rx_data))
        else $error("Receive data not from analog receiver");

endmodule
`default_nettype wire

// ---- design/ads_top.sv ----
// Antenna driver signal select: drive levels and conductance codes
// for the two antenna outputs, plus the serial data switch.
// Assumes register ports are static words from the same clock.
// A control change shows one clock later; a change of envelope
// source mid-carrier may give one long carrier half at the pin.
`timescale 1ns/10ps
`default_nettype none
module ads_top
    import ads_pkg::*;
#(
    parameter int P_W = PMOS_W,
    parameter int N_W = NMOS_W
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [REG_W-1:0] transmit_control_reg,
    input  wire logic [REG_W-1:0] transmit_mode_reg,
    input  wire logic [REG_W-1:0] transmit_source_select_reg,
    input  wire logic [REG_W-1:0] receive_source_select_reg,
    input  wire logic [P_W-1:0]   cw_pmos_conductance_reg,
    input  wire logic [P_W-1:0]   mod_pmos_conductance_reg,
    input  wire logic [2*N_W-1:0] nmos_conductance_reg,
    input  wire logic             tx_envelope,
    input  wire logic             tx_encoded,
    input  wire logic             analog_rx_data,
    input  wire logic             modem_input_pin,
    output logic                  antenna_out_a,
    output logic                  antenna_out_b,
    output logic [P_W-1:0]        pmos_sel_a,
    output logic [P_W-1:0]        pmos_sel_b,
    output logic [N_W-1:0]        nmos_sel_a,
    output logic [N_W-1:0]        nmos_sel_b,
    output logic                  modem_output_pin,
    output logic                  rx_serial_data,
    output logic [SPEED_W-1:0]    tx_speed_code,
    output logic                  tx_framing_en
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Field positions in the package assume these widths
    if (P_W < 1 || P_W > REG_W) begin : g_pw_chk
        $error("PMOS width out of range");
    end
    if (N_W != NMOS_W) begin : g_nw_chk
        $error("NMOS field width must match register layout");
    end

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    ads_sig_if sig ();

    ads_carrier_div u_div (
        .clock (clock),
        .nrst  (nrst),
        .sig   (sig)
    );

    ads_data_switch u_sw (
        .clock            (clock),
        .nrst             (nrst),
        .mout_sel         (transmit_source_select_reg[TXS_MOUT_LSB +: 4]),
        .drv_sel          (transmit_source_select_reg[TXS_DRV_LSB +: 2]),
        .rx_sel           (receive_source_select_reg[RXS_SRC_LSB +: 2]),
        .tx_envelope      (tx_envelope),
        .tx_encoded       (tx_encoded),
        .analog_rx_data   (analog_rx_data),
        .modem_input_pin  (modem_input_pin),
        .modem_output_pin (modem_output_pin),
        .rx_serial_data   (rx_serial_data),
        .sig              (sig)
    );

    // ------------------------------------------------------------
    // Decoding functions
    // ------------------------------------------------------------
    // Level of one output; disabled outputs park low for quiet pins
    function automatic logic drive_level(
        input logic en,
        input logic cw,
        input logic force_ask,
        input logic inv_on,
        input logic inv_off,
        input logic env,
        input logic rf
    );
        logic lvl;
        lvl = 1'b0;
        if (!en) begin
            lvl = 1'b0;
        end else if (cw || env) begin
            lvl = inv_on ? ~rf : rf;
        end else if (force_ask) begin
            lvl = 1'b0;
        end else begin
            lvl = inv_off ? ~rf : rf;
        end
        return lvl;
    endfunction

    // Conductance set in use: CW unless modulating
    function automatic logic use_cw(
        input logic cw,
        input logic env
    );
        return cw | env;
    endfunction

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    logic en_a, en_b, force_ask, cw_b;
    logic inv1_on, inv1_off, inv2_on, inv2_off;
    logic env;
    logic [N_W-1:0] nmos_cw, nmos_mod;

    // Bits taken straight from the control register and the NMOS conductance register
    assign en_a      = transmit_control_reg[CTL_OUT1_EN];
    assign en_b      = transmit_control_reg[CTL_OUT2_EN];
    assign force_ask = transmit_control_reg[CTL_FORCE_ASK];
    assign cw_b      = transmit_control_reg[CTL_OUT2_CW];
    assign inv1_on   = transmit_control_reg[CTL_INV1_ON];
    assign inv1_off  = transmit_control_reg[CTL_INV1_OFF];
    assign inv2_on   = transmit_control_reg[CTL_INV2_ON];
    assign inv2_off  = transmit_control_reg[CTL_INV2_OFF];
    assign nmos_cw   = nmos_conductance_reg[NMOS_CW_LSB +: N_W];
    assign nmos_mod  = nmos_conductance_reg[NMOS_MOD_LSB +: N_W];

    // Mode register may invert the envelope seen by the drivers
    assign env = sig.drive_env ^ transmit_mode_reg[TXM_INVMOD];

    // ------------------------------------------------------------
    // Output state
    // ------------------------------------------------------------
    logic             out_a_reg, out_a_next;
    logic             out_b_reg, out_b_next;
    logic [P_W-1:0]   pa_reg, pa_next, pb_reg, pb_next;
    logic [N_W-1:0]   na_reg, na_next, nb_reg, nb_next;
    logic [SPEED_W-1:0] speed_reg, speed_next;
    logic             frame_reg, frame_next;

    // Next values; levels use the next carrier phase so the
    // registered outputs stay in step with the divider
    always_comb begin
        logic cwa, cwb;
        logic [P_W-1:0] pa, pb;
        logic [N_W-1:0] na, nb;
        cwa = use_cw(1'b0, env);
        cwb = use_cw(cw_b, env);
        pa  = cwa ? cw_pmos_conductance_reg
                  : mod_pmos_conductance_reg;
        na  = cwa ? nmos_cw : nmos_mod;
        pb  = cwb ? cw_pmos_conductance_reg
                  : mod_pmos_conductance_reg;
        nb  = cwb ? nmos_cw : nmos_mod;
        out_a_next = drive_level(en_a, 1'b0, force_ask, inv1_on,
                                 inv1_off, env, sig.carrier_next);
        out_b_next = drive_level(en_b, cw_b, force_ask, inv2_on,
                                 inv2_off, env, sig.carrier_next);
        // A lone driver lends its setting to the idle one
        if (en_a && !en_b) begin
            pb = pa;
            nb = na;
        end else if (en_b && !en_a) begin
            pa = pb;
            na = nb;
        end
        pa_next    = pa;
        na_next    = na;
        pb_next    = pb;
        nb_next    = nb;
        speed_next = transmit_mode_reg[TXM_SPEED_LSB +: SPEED_W];
        frame_next = transmit_mode_reg[TXM_FRAME];
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_a_reg <= OUT_RST;
            out_b_reg <= OUT_RST;
            pa_reg    <= '0;
            pb_reg    <= '0;
            na_reg    <= '0;
            nb_reg    <= '0;
            speed_reg <= '0;
            frame_reg <= OUT_RST;
        end else begin
            out_a_reg <= out_a_next;
            out_b_reg <= out_b_next;
            pa_reg    <= pa_next;
            pb_reg    <= pb_next;
            na_reg    <= na_next;
            nb_reg    <= nb_next;
            speed_reg <= speed_next;
            frame_reg <= frame_next;
        end
    end

    // Outputs come straight from the registers above
    assign antenna_out_a = out_a_reg;
    assign antenna_out_b = out_b_reg;
    assign pmos_sel_a    = pa_reg;
    assign pmos_sel_b    = pb_reg;
    assign nmos_sel_a    = na_reg;
    assign nmos_sel_b    = nb_reg;
    assign tx_speed_code = speed_reg;
    assign tx_framing_en = frame_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // Output one: parking, carrier polarity and code selection; also sharing, output two CW mode, forced ASK, rate code, output two disable
    a_off_parks_low: assert property (
        !en_a |=> !antenna_out_a)
        else $error("Disabled output one not parked low");
    a_true_carrier: assert property (
        en_a && env && !inv1_on |=> antenna_out_a == sig.carrier)
        else $error("Output one does not follow carrier");
    a_invert_on: assert property (
        en_a && env && inv1_on |=> antenna_out_a != sig.carrier)
        else $error("Output one not inverted carrier");
    a_pmos_cw: assert property (
        en_a && env |=> pmos_sel_a == $past(cw_pmos_conductance_reg))
        else $error("PMOS code not CW value");
    a_pmos_mod: assert property (
        en_a && !env |=> pmos_sel_a == $past(mod_pmos_conductance_reg))
        else $error("PMOS code not modulation value");
    a_nmos_cw: assert property (
        en_a && env |=> nmos_sel_a == $past(nmos_cw))
        else $error("NMOS code not CW field");
    a_nmos_mod: assert property (
        en_a && !env |=> nmos_sel_a == $past(nmos_mod))
        else $error("NMOS code not modulation field");
    a_single_share: assert property (
        en_a != en_b |=> pmos_sel_a == pmos_sel_b
                         && nmos_sel_a == nmos_sel_b)
        else $error("Lone driver setting not shared");
    a_out2_cw_mode: assert property (
        en_b && cw_b && !env |=> pmos_sel_b == $past(cw_pmos_conductance_reg)
            && antenna_out_b == (sig.carrier ^ $past(inv2_on)))
        else $error("Output two CW mode wrong");
    a_force_low: assert property (
        (en_a && force_ask && !env) [*2]
            |-> !antenna_out_a ##1 !antenna_out_a)
        else $error("Forced ASK did not hold output low");
    a_speed_follow: assert property (
        $stable(transmit_mode_reg) |=> tx_speed_code
            == $past(transmit_mode_reg[TXM_SPEED_LSB +: SPEED_W]))
        else $error("Rate code not from mode register");
    a_out2_disable: assert property (
        !en_b ##1 !en_b |-> !antenna_out_b)
        else $error("Control enable ignored on output two");

    // Output two: polarity, forced ASK and code selection
    a_out2_true_carrier: assert property (
        en_b && (cw_b || env) && !inv2_on
            |=> antenna_out_b == sig.carrier)
        else $error("Output two does not follow carrier");
    a_out2_force_low: assert property (
        en_b && !cw_b && force_ask && !env |=> !antenna_out_b)
        else $error("Forced ASK did not pull output two low");
    a_out2_pmos_mod: assert property (
        en_b && !cw_b && !env
            |=> pmos_sel_b == $past(mod_pmos_conductance_reg))
        else $error("Output two PMOS code not modulation value");
    a_out2_nmos_cw: assert property (
        en_b && cw_b |=> nmos_sel_b == $past(nmos_cw))
        else $error("Output two CW mode not on CW NMOS field");

    // Output one low-envelope invert and the mode register copy
    a_inv_off: assert property (
        en_a && !env && !force_ask && inv1_off
            |=> antenna_out_a != sig.carrier)
        else $error("Output one ignores invert-when-off bit");
    a_frame_follow: assert property (
        1'b1 |=> tx_framing_en
            == $past(transmit_mode_reg[TXM_FRAME]))
        else $error("Framing enable not from mode register");

    // Scenario covers: both outputs on, forced ASK on each output, output two CW and lone output two
    c_both_on: cover property (en_a && en_b && env ##1 antenna_out_a);
    c_forced_ask: cover property (en_a && force_ask && !env);
    c_out2_cw: cover property (en_b && cw_b && !env);
    c_lone_b: cover property (en_b && !en_a ##1 pmos_sel_a == pmos_sel_b);
    c_out2_forced: cover property (en_b && !cw_b && force_ask && !env);

endmodule
`default_nettype wire

// ---- tb/ads_far_end.sv ----
// Far-side model: modem input source and analog receiver stage.
// Assumes the bench sets the requested levels just after an edge.
`timescale 1ns/10ps
`default_nettype none
module ads_far_end (
    input  wire logic clock,
    input  wire logic pin_req,
    input  wire logic rx_req,
    output logic      modem_input_pin,
    output logic      analog_rx_data
);
    // Start low so the design never sees an unknown at time zero
    initial begin
        modem_input_pin = 1'b0;
        analog_rx_data  = 1'b0;
    end

    // A real source moves after the edge, one cycle behind the request
    always @(posedge clock) begin
        modem_input_pin <= pin_req;
        analog_rx_data  <= rx_req;
    end
endmodule
`default_nettype wire

// ---- tb/ads_top_tb.sv ----
// Self-checking bench for the antenna driver signal select block.
// Assumes ads_top with default widths and the far-side model.
`timescale 1ns/10ps
`default_nettype none
module ads_top_tb;
    import ads_pkg::*;
    logic       clock, nrst, env_in, enc, pin_req, rx_req, mpin, arx;
    logic       out_a, out_b, mout, rxd, framing, a1, b1, rf_model;
    logic [7:0] ctl, mode, txs, rxs, nreg;
    logic [5:0] pmos_cw_value, pmos_mod_value, psa, psb;
    logic [3:0] nsa, nsb;
    logic [2:0] speed;
    int         n_errors, check_count;
    int         env, ka, kb, pa, pb, na, nb;

    ads_top u_ads_top (.clock(clock), .nrst(nrst),
        .transmit_control_reg(ctl), .transmit_mode_reg(mode),
        .transmit_source_select_reg(txs), .receive_source_select_reg(rxs),
        .cw_pmos_conductance_reg(pmos_cw_value), .mod_pmos_conductance_reg(pmos_mod_value),
        .nmos_conductance_reg(nreg), .tx_envelope(env_in),
        .tx_encoded(enc), .analog_rx_data(arx), .modem_input_pin(mpin),
        .antenna_out_a(out_a), .antenna_out_b(out_b), .pmos_sel_a(psa),
        .pmos_sel_b(psb), .nmos_sel_a(nsa), .nmos_sel_b(nsb),
        .modem_output_pin(mout), .rx_serial_data(rxd),
        .tx_speed_code(speed), .tx_framing_en(framing));

    ads_far_end u_ads_far_end (.clock(clock), .pin_req(pin_req),
        .rx_req(rx_req), .modem_input_pin(mpin), .analog_rx_data(arx));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Drive level kind: 0 low, 1 true carrier, 2 inverted carrier
    function automatic int kind(bit en, bit cw, bit fa, bit ion, bit ioff,
                                int e);
        if (!en) return 0;
        if (cw || e != 0) return ion ? 2 : 1;
        if (fa) return 0;
        return ioff ? 2 : 1;
    endfunction

    // Free-running clock, 10 ns period
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Carrier model: held low in reset, then one toggle per rising clock edge
    always @(posedge clock) begin
        rf_model <= nrst ? ~rf_model : 1'b0;
    end

    // A hang would otherwise leave the run open
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence: every control word with both envelope levels
    // ------------------------------------------------------------
    initial begin
        {nrst, ctl, mode, txs, rxs, nreg, pmos_cw_value, pmos_mod_value} = '0;
        {env_in, enc, pin_req, rx_req} = '0;
        void'($urandom(45048));
        repeat (20) @(posedge clock);
        check("reset out_a", {7'h0, out_a}, 8'h00);
        nrst <= 1'b1;
        for (int i = 0; i < 512; i++) begin
            @(posedge clock);
            // Second reset in mid run: outputs clear, carrier restarts
            if (i == 256) begin
                nrst <= 1'b0;
                repeat (3) @(negedge clock);
                check("mid reset", {out_a, out_b, mout, rxd, framing, speed}, 8'h00);
                @(posedge clock);
                nrst <= 1'b1;
            end
            ctl     <= i[7:0];
            env_in  <= i[8];
            mode    <= 8'($urandom);
            txs     <= 8'($urandom);
            rxs     <= 8'($urandom);
            nreg    <= 8'($urandom);
            pmos_cw_value     <= 6'($urandom);
            pmos_mod_value    <= 6'($urandom);
            enc     <= 1'($urandom);
            pin_req <= 1'($urandom);
            rx_req  <= 1'($urandom);
            // Pin paths need three cycles plus the far-side flop
            repeat (6) @(posedge clock);
            @(negedge clock);
            a1 = out_a;
            b1 = out_b;
            @(negedge clock);
            // Envelope source then optional inversion
            case (txs[5:4])
                2'h1: env = env_in;
                2'h2: env = pin_req;
                2'h3: env = 1;
                default: env = 0;
            endcase
            env = env ^ mode[3];
            ka = kind(ctl[0], 1'b0, ctl[2], ctl[6], ctl[4], env);
            kb = kind(ctl[1], ctl[3], ctl[2], ctl[7], ctl[5], env);
            check("a level", {7'h0, out_a}, 8'(ka == 0 ? 0 : rf_model ^ (ka == 2)));
            check("b level", {7'h0, out_b}, 8'(kb == 0 ? 0 : rf_model ^ (kb == 2)));
            if (ka != 0 && kb != 0)
                check("a b phase", {7'h0, a1 ^ b1}, 8'(ka != kb));
            pa = env != 0 ? pmos_cw_value : pmos_mod_value;
            na = env != 0 ? nreg[7:4] : nreg[3:0];
            pb = (env != 0 || ctl[3]) ? pmos_cw_value : pmos_mod_value;
            nb = (env != 0 || ctl[3]) ? nreg[7:4] : nreg[3:0];
            if (ctl[0] && !ctl[1]) begin
                pb = pa;
                nb = na;
            end
            if (ctl[1] && !ctl[0]) begin
                pa = pb;
                na = nb;
            end
            if (ctl[1:0] != 2'h0) begin
                check("pmos a", {2'h0, psa}, 8'(pa));
                check("pmos b", {2'h0, psb}, 8'(pb));
                check("nmos a", {4'h0, nsa}, 8'(na));
                check("nmos b", {4'h0, nsb}, 8'(nb));
            end
            case (txs[3:0])
                MOUT_HIGH: pa = 1;
                MOUT_ENV:  pa = env_in;
                MOUT_ENC:  pa = enc;
                MOUT_RX:   pa = rx_req;
                default:   pa = 0;
            endcase
            check("modem out", {7'h0, mout}, 8'(pa));
            pb = rxs[7:6] == 2'h0 ? 0 : rxs[7:6] == 2'h1 ? pin_req : rx_req;
            check("rx data", {7'h0, rxd}, 8'(pb));
            check("speed", {5'h0, speed}, {5'h0, mode[6:4]});
            check("framing", {7'h0, framing}, {7'h0, mode[7]});
        end
        test_done();
    end
endmodule
`default_nettype wire
